// [testbench.sv]
`timescale 1ns/100ps
`include "wgte_map.vh"
module testbench;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tb_20m_tick = 1'b0, feed_valid = 1'b0;
   reg [15:0] feed_data = 16'h0000;
   reg [8:0] oth = 9'h000;
   reg [31:0] rv;
   reg [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, feed_ready;
   wire dac_update, gen_start_trigger, gen_update_clock;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] general_io_lines_in, general_io_lines_out, general_io_lines_oe, dac_data;
   integer miscompares = 0, num_checks = 0, cyc = 0, fc = 0, n0, t0, nb, j, k;
   // Other engines' signals come from one vector so every one can be pulsed
   wgte_engine uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tb_100m_tick(1'b1),
      .tb_20m_tick, .acq_start_trigger(oth[0]), .dig_in_start_trigger(oth[1]),
      .dig_out_start_trigger(oth[2]), .counter_out(oth[3]), .change_detect_event(oth[4]),
      .acq_sample_clock(oth[5]), .acq_conversion_clock(oth[6]), .dig_in_sample_clock(oth[7]),
      .dig_out_sample_clock(oth[8]), .general_io_lines_in, .general_io_lines_out,
      .general_io_lines_oe, .feed_valid, .feed_data, .feed_ready, .dac_data, .dac_update,
      .gen_start_trigger, .gen_update_clock);
   wgte_far_model far (.aclk, .general_io_lines_out, .general_io_lines_oe,
      .general_io_lines_in, .dac_update, .gen_start_trigger);
   always #50 aclk = ~aclk;
   // Slow tick, host feed counter and hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      tb_20m_tick <= (cyc % 5 == 4);
      if (feed_valid && feed_ready) begin
         fc <= fc + 1;
         feed_data <= feed_data + 16'h0001;
      end
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Address and data offered together; answer accepted late to exercise the hold
   task wr(input [7:0] a, input [31:0] d);
      reg ta, tw;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         ta = 0;
         tw = 0;
         while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && s_axi_awready) begin ta = 1; s_axi_awvalid <= 1'b0; end
            if (!tw && s_axi_wready) begin tw = 1; s_axi_wvalid <= 1'b0; end
         end
         while (!s_axi_bvalid) @(posedge aclk);
         rsp = s_axi_bresp;
         s_axi_bready <= 1'b1;
         @(posedge aclk);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         @(posedge aclk);
         while (!s_axi_arready) @(posedge aclk);
         s_axi_arvalid <= 1'b0;
         while (!s_axi_rvalid) @(posedge aclk);
         s_axi_rready <= 1'b1;
         @(posedge aclk);
         rv = s_axi_rdata;
         rsp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task rc(input [7:0] a, input [31:0] e);
      begin rd(a); chk("reg", rv, e); end
   endtask
   // Bounded wait for a total of conversions, then a quiet spell
   task waitupd(input integer n);
      begin
         k = 0;
         while (far.upd < n && k < 2000) begin @(posedge aclk); k = k + 1; end
         repeat (20) @(posedge aclk);
      end
   endtask
   task osc(input integer b);
      begin oth[b] <= 1'b1; @(posedge aclk); oth[b] <= 1'b0; repeat (3) @(posedge aclk); end
   endtask
   task fire(input integer s);
      begin
         if (s == 0) wr(`WGTE_CTRL, 32'h10);
         else if (s == 1) far.pulse(4'd5);
         else osc(s - 2);
      end
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(`WGTE_MODE, 32'h004);
      rc(`WGTE_DELAY, 32'h2);
      rc(`WGTE_DIV, 32'h2);
      rd(8'h40);
      chk("resp", {30'h0, rsp}, {30'h0, `WGTE_SLVERR});
      wr(8'h40, 32'h0);
      chk("wresp", {30'h0, rsp}, {30'h0, `WGTE_SLVERR});
      // Host-paced updates
      wr(`WGTE_MODE, 32'h0);
      for (j = 0; j < 2; j = j + 1) begin
         n0 = far.upd;
         wr(`WGTE_SWDAT, 32'h1234 + j * 32'h1111);
         wr(`WGTE_CTRL, 32'h4);
         repeat (4) @(posedge aclk);
         chk("sw upd", far.upd, n0 + 1);
         chk("dac", {16'h0, dac_data}, 32'h1234 + j * 32'h1111);
      end
      // Finite runs on each fixed timebase
      wr(`WGTE_ROUTE, 32'h1713);
      wr(`WGTE_COUNT, 32'h3);
      wr(`WGTE_MODE, 32'h5);
      feed_valid <= 1'b1;
      nb = far.upd;
      for (j = 0; j < 3; j = j + 1) begin
         wr(`WGTE_CSEL, j << 8);
         n0 = far.upd;
         t0 = far.trg;
         wr(`WGTE_CTRL, 32'h1);
         waitupd(n0 + 3);
         chk("count", far.upd, n0 + 3);
         chk("gap", far.gap, 2 * (j == 0 ? 1 : j == 1 ? 5 : 100));
         chk("trig", far.trg, t0 + 1);
      end
      chk("low pulses", far.low_cnt, far.upd - nb);
      chk("trig out", far.hi_cnt, far.trg);
      // Continuous until stopped
      wr(`WGTE_CSEL, 32'h0);
      wr(`WGTE_MODE, 32'h7);
      n0 = far.upd;
      wr(`WGTE_CTRL, 32'h1);
      repeat (100) @(posedge aclk);
      wr(`WGTE_CTRL, 32'h2);
      repeat (5) @(posedge aclk);
      t0 = far.upd;
      chk("run on", {31'h0, far.upd > n0 + 3}, 32'h1);
      repeat (50) @(posedge aclk);
      chk("stopped", far.upd, t0);
      // Every trigger kind; second pulse lands mid-sequence, third rearms
      wr(`WGTE_DIV, 32'h4);
      wr(`WGTE_MODE, 32'h35);
      for (j = 0; j < 7; j = j + 1) begin
         wr(`WGTE_CTRL, 32'h2);
         wr(`WGTE_TRIG, (j << 4) | 5);
         n0 = far.upd;
         t0 = far.trg;
         wr(`WGTE_CTRL, 32'h1);
         repeat (3) @(posedge aclk);
         fire(j);
         fire(j);
         waitupd(n0 + 3);
         fire(j);
         waitupd(n0 + 6);
         chk("retrig upd", far.upd, n0 + 6);
         chk("retrig trg", far.trg, t0 + 2);
      end
      // Line, internal and undivided external clocks
      wr(`WGTE_CTRL, 32'h2);
      wr(`WGTE_MODE, 32'h5);
      for (j = 1; j < 9; j = j + 1) begin
         wr(`WGTE_CSEL, j < 8 ? (j | 32'h90) : 32'h2700);
         if (j == 8) wr(`WGTE_MODE, 32'h105);
         n0 = far.upd;
         wr(`WGTE_CTRL, 32'h1);
         repeat (3) @(posedge aclk);
         repeat (3) if (j == 1 || j == 8) far.pulse(4'd9); else osc(j + 1);
         repeat (10) @(posedge aclk);
         chk("ext clk", far.upd, n0 + 3);
      end
      // Starved feed without repeat
      feed_valid <= 1'b0;
      wr(`WGTE_CSEL, 32'h0);
      wr(`WGTE_MODE, 32'h3);
      wr(`WGTE_CTRL, 32'h1);
      repeat (30) @(posedge aclk);
      rd(`WGTE_STAT);
      chk("underflow", {31'h0, rv[2]}, 32'h1);
      // Stop first: a pulse landing on the clear would set the flag again
      wr(`WGTE_CTRL, 32'h2);
      wr(`WGTE_CTRL, 32'h8);
      rd(`WGTE_STAT);
      chk("uf clear", {31'h0, rv[2]}, 32'h0);
      // Local replay takes one buffer only
      wr(`WGTE_BLEN, 32'h3);
      wr(`WGTE_MODE, 32'hB);
      t0 = fc;
      wr(`WGTE_CTRL, 32'h1);
      feed_valid <= 1'b1;
      repeat (100) @(posedge aclk);
      chk("feed words", fc - t0, 4);
      chk("stray oe", {31'h0, far.stray}, 32'h0);
      give_verdict;
   end
endmodule // testbench

// [wgte_engine.v]
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "wgte_map.vh"
// Notes on behaviour
// - Software-timed mode: one DAC update per host update command, no pacing.
// - Finite mode stops after the programmed sample count.
// - Continuous mode runs until an explicit stop command.
// - Repeat mode replays buffer while host may overwrite it freely.
// - Local replay loads whole buffer once, then replays without host traffic.
// - Non-repeat mode never reuses data; missing data flags underflow.
// - Start on trigger, or on software start when trigger is off.
// - Retrigger mode runs a full sequence for each trigger pulse taken while armed.
// - Triggers ignored while running; rearm only after the sequence ends.
// - Trigger source selectable, edge selectable rising or falling.
// - Start trigger routable to any line as active-high pulse.
// - Each update clock edge updates all DAC channels together.
// - Update clock from divider or selected internal clock sources.
// - Any of sixteen lines selectable as external update clock.
// - Update clock routable to any line, active low.
// - Clock internal unless external chosen; start by trigger, stop after finite.
// - Programmable delay from trigger to first pulse on the divided timebase only, default two ticks.
// - Timebase from 100 MHz, 20 MHz, 100 kHz or a line.
// - Timebase is never driven onto any line.
// - External clock usable as divided timebase or directly undivided.
module wgte_engine (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Fast timebase ticks, same clock domain
   input wire tb_100m_tick,
   input wire tb_20m_tick,
   // Other engines' signals, same clock domain
   input wire acq_start_trigger,
   input wire dig_in_start_trigger,
   input wire dig_out_start_trigger,
   input wire counter_out,
   input wire change_detect_event,
   input wire acq_sample_clock,
   input wire acq_conversion_clock,
   input wire dig_in_sample_clock,
   input wire dig_out_sample_clock,
   // General lines
   input wire [15:0] general_io_lines_in,
   output reg [15:0] general_io_lines_out,
   output reg [15:0] general_io_lines_oe,
   // Host feed
   input wire feed_valid,
   input wire [15:0] feed_data,
   output wire feed_ready,
   // DAC side
   output reg [15:0] dac_data,
   output reg dac_update,
   output reg gen_start_trigger,
   output reg gen_update_clock
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_ARM = 4'h2;
   localparam [3:0] ST_DLY = 4'h4;
   localparam [3:0] ST_RUN = 4'h8;
   localparam integer SLOW_LAST_I = `WGTE_SLOW_DIV - 1;
   localparam [6:0] SLOW_LAST = SLOW_LAST_I[6:0];

   reg [9:0] mode_r;
   reg [6:0] trig_r;
   reg [13:0] csel_r;
   reg [15:0] div_r, delay_r, count_r, sw_data_r;
   reg [12:0] route_r;
   reg [3:0] blen_r;
   reg [3:0] st_r;
   reg [15:0] dly_cnt_r, div_cnt_r, samp_cnt_r;
   reg uf_r, done_r, loaded_r;
   reg [3:0] rd_ptr_r, wr_ptr_r;
   reg [15:0] mem [0:15];
   reg [15:0] dio_s1_r, dio_s2_r, dio_s3_r;
   reg [8:0] ip_r;
   reg [6:0] slow_cnt_r;
   reg aw_hold_r, w_hold_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;

   // Pick one of sixteen lines
   function sel16;
      input [15:0] v;
      input [3:0] i;
      begin
         sel16 = v[i];
      end
   endfunction

   // Edge detect with selectable polarity
   function edge_of;
      input cur, prev, fall;
      begin
         edge_of = fall ? (prev & ~cur) : (cur & ~prev);
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `WGTE_SWDAT);
      end
   endfunction

   // Register readback, also the base for byte-lane merges
   function [31:0] rmap;
      input [7:0] a;
      begin
         case (a)
            `WGTE_MODE: rmap = {22'h0, mode_r};
            `WGTE_TRIG: rmap = {25'h0, trig_r};
            `WGTE_CSEL: rmap = {18'h0, csel_r};
            `WGTE_DIV: rmap = {16'h0, div_r};
            `WGTE_DELAY: rmap = {16'h0, delay_r};
            `WGTE_COUNT: rmap = {16'h0, count_r};
            `WGTE_ROUTE: rmap = {19'h0, route_r};
            `WGTE_STAT: rmap = {samp_cnt_r, 11'h0, loaded_r, done_r, uf_r,
               st_r[1], ~st_r[0]};
            `WGTE_BLEN: rmap = {28'h0, blen_r};
            `WGTE_SWDAT: rmap = {16'h0, sw_data_r};
            default: rmap = 32'h0;
         endcase
      end
   endfunction

   // Bus handshakes; one write and one read outstanding
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire wr_go = aw_hold_r & w_hold_r;
   wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
      {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [31:0] wval = (rmap(aw_addr_r) & ~wmask) | (w_data_r & wmask);
   wire ctrl_wr = wr_go && (aw_addr_r == `WGTE_CTRL) && w_strb_r[0];
   wire cmd_start = ctrl_wr & w_data_r[`WGTE_C_START];
   wire cmd_stop = ctrl_wr & w_data_r[`WGTE_C_STOP];
   wire cmd_swupd = ctrl_wr & w_data_r[`WGTE_C_SWUPD];
   wire cmd_clruf = ctrl_wr & w_data_r[`WGTE_C_CLRUF];
   wire cmd_swtrig = ctrl_wr & w_data_r[`WGTE_C_SWTRIG];

   // Bus channel state
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `WGTE_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `WGTE_OKAY;
         s_axi_rdata <= 32'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_r) ? `WGTE_OKAY : `WGTE_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmap(s_axi_araddr);
            s_axi_rresp <= mapped(s_axi_araddr) ? `WGTE_OKAY : `WGTE_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; status and CTRL are not stored
   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= `WGTE_MODE_RST;
         trig_r <= 7'h00;
         csel_r <= 14'h0000;
         div_r <= `WGTE_DIV_RST;
         delay_r <= `WGTE_DELAY_RST;
         count_r <= `WGTE_COUNT_RST;
         route_r <= 13'h0000;
         blen_r <= 4'hF;
         sw_data_r <= 16'h0000;
      end else if (wr_go) begin
         case (aw_addr_r)
            `WGTE_MODE: mode_r <= wval[9:0];
            `WGTE_TRIG: trig_r <= wval[6:0];
            `WGTE_CSEL: csel_r <= wval[13:0];
            `WGTE_DIV: div_r <= wval[15:0];
            `WGTE_DELAY: delay_r <= wval[15:0];
            `WGTE_COUNT: count_r <= wval[15:0];
            `WGTE_ROUTE: route_r <= wval[12:0];
            `WGTE_BLEN: blen_r <= wval[3:0];
            `WGTE_SWDAT: sw_data_r <= wval[15:0];
            default: ;
         endcase
      end
   end

   // Line synchronisers; stage one is read only by stage two
   always @(posedge aclk) begin
      if (!aresetn) begin
         dio_s1_r <= 16'h0000;
         dio_s2_r <= 16'h0000;
         dio_s3_r <= 16'h0000;
         ip_r <= 9'h000;
      end else begin
         dio_s1_r <= general_io_lines_in;
         dio_s2_r <= dio_s1_r;
         dio_s3_r <= dio_s2_r;
         ip_r <= {dig_out_sample_clock, dig_in_sample_clock, acq_conversion_clock,
            acq_sample_clock, change_detect_event, counter_out,
            dig_out_start_trigger, dig_in_start_trigger, acq_start_trigger};
      end
   end

   // 100 kHz timebase enable from the system clock
   wire slow_tick = (slow_cnt_r == SLOW_LAST);
   always @(posedge aclk) begin
      if (!aresetn)
         slow_cnt_r <= 7'h00;
      else
         slow_cnt_r <= slow_tick ? 7'h00 : slow_cnt_r + 7'h01;
   end

   // Timebase choice; it feeds the divider, or the update pulse in direct mode, never a line
   wire tb_dio = edge_of(sel16(dio_s2_r, csel_r[13:10]),
      sel16(dio_s3_r, csel_r[13:10]), mode_r[`WGTE_M_TBFALL]);
   reg tb_tick;
   always @* begin
      case (csel_r[9:8])
         2'h0: tb_tick = tb_100m_tick;
         2'h1: tb_tick = tb_20m_tick;
         2'h2: tb_tick = slow_tick;
         default: tb_tick = tb_dio;
      endcase
   end

   // Trigger sources; kind 0 is the host pulse
   wire [6:0] t_cur = {ip_r[4:0] & 5'h00 | {change_detect_event, counter_out,
      dig_out_start_trigger, dig_in_start_trigger, acq_start_trigger},
      sel16(dio_s2_r, trig_r[3:0]), 1'b0};
   wire [6:0] t_prv = {ip_r[4], ip_r[3], ip_r[2], ip_r[1], ip_r[0],
      sel16(dio_s3_r, trig_r[3:0]), 1'b0};
   wire [2:0] tk = trig_r[6:4];
   wire trig_hit = (tk == 3'h0) ? cmd_swtrig : (tk == 3'h7) ? 1'b0 :
      edge_of(t_cur[tk], t_prv[tk], mode_r[`WGTE_M_TFALL]);

   // Update clock sources; source 0 is the timebase, through the divider unless direct
   wire [7:0] c_cur = {dig_out_sample_clock, dig_in_sample_clock,
      acq_conversion_clock, acq_sample_clock, change_detect_event, counter_out,
      sel16(dio_s2_r, csel_r[7:4]), 1'b0};
   wire [7:0] c_prv = {ip_r[8:3], sel16(dio_s3_r, csel_r[7:4]), 1'b0};
   wire [2:0] ck = csel_r[2:0];
   wire ext_upd = edge_of(c_cur[ck], c_prv[ck], mode_r[`WGTE_M_CFALL]);
   wire direct = mode_r[`WGTE_M_DIRECT];
   wire use_div = (ck == 3'h0) & ~direct;

   // Update pulse decision
   reg fire;
   always @* begin
      fire = 1'b0;
      if (st_r == ST_DLY)
         fire = use_div & tb_tick & (dly_cnt_r <= 16'h0001);
      else if (st_r == ST_RUN) begin
         if (ck != 3'h0)
            fire = ext_upd;
         else if (direct)
            fire = tb_tick;
         else
            fire = tb_tick & (div_cnt_r <= 16'h0001);
      end
   end

   wire hw = mode_r[`WGTE_M_HW];
   wire local_rp = mode_r[`WGTE_M_LOCAL];
   wire repeat_rp = mode_r[`WGTE_M_REPEAT] & ~local_rp;
   wire fresh = ~mode_r[`WGTE_M_REPEAT] & ~local_rp;
   wire trig_take = (st_r == ST_ARM) & (~mode_r[`WGTE_M_TRIGEN] | trig_hit);
   wire last = ~mode_r[`WGTE_M_CONT] & (samp_cnt_r + 16'h0001 >= count_r);
   // Local replay shuts the feed once loaded; fresh data only on a pulse
   assign feed_ready = local_rp ? ~loaded_r : (repeat_rp | (fire & fresh));
   wire feed_take = feed_valid & feed_ready;

   // Sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_IDLE;
         dly_cnt_r <= 16'h0000;
         div_cnt_r <= 16'h0000;
         samp_cnt_r <= 16'h0000;
         done_r <= 1'b0;
      end else if (cmd_stop) begin
         st_r <= ST_IDLE;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (cmd_start & hw) begin
                  st_r <= ST_ARM;
                  done_r <= 1'b0;
               end
            end
            ST_ARM: begin
               if (trig_take) begin
                  st_r <= ST_DLY;
                  dly_cnt_r <= delay_r;
                  samp_cnt_r <= 16'h0000;
               end
            end
            ST_DLY: begin
               if (~use_div | fire)
                  st_r <= ST_RUN;
               else if (tb_tick)
                  dly_cnt_r <= dly_cnt_r - 16'h0001;
               div_cnt_r <= div_r;
            end
            ST_RUN: begin
               if (use_div & tb_tick)
                  div_cnt_r <= fire ? div_r : div_cnt_r - 16'h0001;
            end
            default: st_r <= ST_IDLE;
         endcase
         // Sample count; finite end rearms or stops
         if (fire) begin
            samp_cnt_r <= samp_cnt_r + 16'h0001;
            if (last) begin
               done_r <= 1'b1;
               st_r <= mode_r[`WGTE_M_RETRIG] ? ST_ARM : ST_IDLE;
            end
         end
      end
   end

   // Buffer, pointers and underflow flag
   always @(posedge aclk) begin
      if (feed_take & ~fresh)
         mem[wr_ptr_r] <= feed_data;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr_r <= 4'h0;
         wr_ptr_r <= 4'h0;
         loaded_r <= 1'b0;
         uf_r <= 1'b0;
      end else begin
         // A fresh start reloads the local buffer from its top
         if (cmd_start & (st_r == ST_IDLE)) begin
            rd_ptr_r <= 4'h0;
            wr_ptr_r <= 4'h0;
            loaded_r <= 1'b0;
         end else begin
            if (feed_take & ~fresh) begin
               wr_ptr_r <= (wr_ptr_r == blen_r) ? 4'h0 : wr_ptr_r + 4'h1;
               if (local_rp & (wr_ptr_r == blen_r))
                  loaded_r <= 1'b1;
            end
            if (fire & ~fresh)
               rd_ptr_r <= (rd_ptr_r == blen_r) ? 4'h0 : rd_ptr_r + 4'h1;
         end
         // Set wins over a clear in the same cycle
         if (fire & fresh & ~feed_valid)
            uf_r <= 1'b1;
         else if (cmd_clruf)
            uf_r <= 1'b0;
      end
   end

   // DAC word and strobes, all channels on one pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         dac_data <= 16'h0000;
         dac_update <= 1'b0;
         gen_start_trigger <= 1'b0;
         gen_update_clock <= 1'b0;
      end else begin
         gen_start_trigger <= trig_take;
         gen_update_clock <= fire;
         dac_update <= fire | (cmd_swupd & ~hw);
         if (cmd_swupd & ~hw)
            dac_data <= sw_data_r;
         else if (fire & fresh & feed_valid)
            dac_data <= feed_data;
         else if (fire & ~fresh)
            dac_data <= mem[rd_ptr_r];
      end
   end

   // Line routing; trigger wins if both pick one line
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_route
         wire t_on = route_r[4] & (route_r[3:0] == gi);
         wire c_on = route_r[12] & (route_r[11:8] == gi);
         always @(posedge aclk) begin
            if (!aresetn) begin
               general_io_lines_out[gi] <= 1'b0;
               general_io_lines_oe[gi] <= 1'b0;
            end else begin
               general_io_lines_out[gi] <= t_on ? trig_take : (c_on & ~fire);
               general_io_lines_oe[gi] <= t_on | c_on;
            end
         end
      end
   endgenerate
endmodule // wgte_engine

// [wgte_engine_asserts.sv]
`timescale 1ns/100ps
module wgte_engine_chk (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Strobes
   input wire dac_update,
   input wire gen_start_trigger,
   input wire gen_update_clock
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Every clock pulse must move all converters at once
   property p_upd_all; gen_update_clock |-> dac_update; endproperty
   a_upd_all: assert property (p_upd_all) else $error("clock pulse without update");
   property p_trig_one; gen_start_trigger |=> !gen_start_trigger; endproperty
   a_trig_one: assert property (p_trig_one) else $error("trigger strobe too long");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer late");
   property p_b_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_ans: assert property (p_b_ans) else $error("write answer late");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
endmodule // wgte_engine_chk
bind wgte_engine wgte_engine_chk chk_i (.*);

// [wgte_far_model.sv]
`timescale 1ns/100ps
module wgte_far_model (
   // Clock
   input wire aclk,
   // Routed lines
   input wire [15:0] general_io_lines_out,
   input wire [15:0] general_io_lines_oe,
   output wire [15:0] general_io_lines_in,
   // Converter side
   input wire dac_update,
   input wire gen_start_trigger
);
   reg [15:0] drv_r = 16'h0000;
   reg [15:0] prev_r = 16'h0000;
   reg stray = 1'b0;
   integer upd = 0, trg = 0, gap = 0, since = 0, low_cnt = 0, hi_cnt = 0;
   // Driven lines read back; released lines carry the model's own pulses, low otherwise
   assign general_io_lines_in = (general_io_lines_out & general_io_lines_oe) |
      (drv_r & ~general_io_lines_oe);
   // Count conversions, triggers and routed pulses; only lines 3 and 7 may drive
   always @(posedge aclk) begin
      since <= dac_update ? 0 : since + 1;
      if (dac_update) begin
         upd <= upd + 1;
         gap <= since + 1;
      end
      if (gen_start_trigger) trg <= trg + 1;
      if (general_io_lines_oe[7] && prev_r[7] && !general_io_lines_out[7]) low_cnt <= low_cnt + 1;
      if (general_io_lines_oe[3] && !prev_r[3] && general_io_lines_out[3]) hi_cnt <= hi_cnt + 1;
      if (|(general_io_lines_oe & ~16'h0088)) stray <= 1'b1;
      prev_r <= general_io_lines_out;
   end
   // Wide pulse so the two-stage synchroniser cannot miss it
   task pulse(input [3:0] n);
      begin
         drv_r[n] <= 1'b1;
         repeat (3) @(posedge aclk);
         drv_r[n] <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule // wgte_far_model

// [wgte_map.vh]
`ifndef WGTE_MAP_VH
`define WGTE_MAP_VH
// Register byte offsets
`define WGTE_CTRL 8'h00
`define WGTE_MODE 8'h04
`define WGTE_TRIG 8'h08
`define WGTE_CSEL 8'h0C
`define WGTE_DIV 8'h10
`define WGTE_DELAY 8'h14
`define WGTE_COUNT 8'h18
`define WGTE_ROUTE 8'h1C
`define WGTE_STAT 8'h20
`define WGTE_BLEN 8'h24
`define WGTE_SWDAT 8'h28
// Command bits in CTRL (write-only pulses)
`define WGTE_C_START 0
`define WGTE_C_STOP 1
`define WGTE_C_SWUPD 2
`define WGTE_C_CLRUF 3
`define WGTE_C_SWTRIG 4
// Mode bits
`define WGTE_M_HW 0
`define WGTE_M_CONT 1
`define WGTE_M_REPEAT 2
`define WGTE_M_LOCAL 3
`define WGTE_M_RETRIG 4
`define WGTE_M_TRIGEN 5
`define WGTE_M_TFALL 6
`define WGTE_M_CFALL 7
`define WGTE_M_DIRECT 8
`define WGTE_M_TBFALL 9
// Reset values
`define WGTE_MODE_RST 10'h004
`define WGTE_DELAY_RST 16'h0002
`define WGTE_DIV_RST 16'h0002
`define WGTE_COUNT_RST 16'h0001
// Timing
`define WGTE_CLK_HZ 10000000
`define WGTE_SLOW_HZ 100000
`define WGTE_SLOW_DIV ((`WGTE_CLK_HZ) / (`WGTE_SLOW_HZ))
// Bus answers
`define WGTE_OKAY 2'h0
`define WGTE_SLVERR 2'h2
`endif
